// File: hdl/rtuslv_top.sv
// Serial register protocol slave: frame check, execute, respond
//
// Summary of operation
// - Reply only to master commands
// - Frame: address, function, data, check field
// - Accept own station address 1..50 or broadcast
// - Broadcast executes without any reply
// - Station setting zero silences all replies
// - Only read, loopback, write functions
// - Read command 8 bytes, reply 7..37
// - Write command 11..41 bytes, reply 8
// - Data field: register address or test code
// - CRC register preset to all ones
// - CRC over address to data, LSB first
// - Read reply: registers high then low
// - Byte count is twice register count
// - Loopback echoes whole command frame
// - Write data high then low, ascending
// - Write reply echoes header, new CRC
// - Error reply: function top bit, code
// - Unit select scales voltage monitor register
// - Link works regardless of source selects
// - Link commands ORed with terminal inputs
// - Wait 5..65 ms before replying
// - Request-to-send only while sending if enabled
`timescale 1ns/1ns
`include "rtuslv_map.svh"
module rtuslv_top import rtuslv_pkg::*; #(
  parameter int unsigned MS_CYCLES = `RTU_MS_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Received bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic [19:0] gap_cycles,
  // Transmitted bytes
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_data,
  output logic             rts,
  // Configuration
  input  wire logic [7:0]  station_address_setting,
  input  wire logic [6:0]  transmit_wait_time,
  input  wire logic        transmit_enable_control_select,
  input  wire logic        voltage_monitor_unit_select,
  // Register access
  output logic      [15:0] reg_addr,
  input  wire logic [15:0] reg_rd_data,
  output logic             reg_wr_en,
  output logic      [15:0] reg_wr_data,
  // Multi-function commands
  input  wire logic [9:0]  multi_function_input_terminals,
  output logic      [9:0]  multi_function_commands
);
  function automatic logic [15:0] pair(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  rtuslv_state_t state_reg;
  rtuslv_kind_t  kind_reg;
  logic [7:0]    rx_buf [0:`RTU_BUF_LEN-1];
  logic [5:0]    rx_cnt_reg;
  logic          rx_ovf_reg;
  logic          frame_end;
  logic [15:0]   crc_rx;
  logic [15:0]   crc_tx;
  logic [5:0]    resp_len_reg;
  logic [7:0]    exc_code_reg;
  logic [5:0]    k_reg;
  logic [15:0]   wr_idx_reg;
  logic [5:0]    wr_ptr_reg;
  logic [19:0]   ms_cnt_reg;
  logic [6:0]    ms_left_reg;
  logic [9:0]    mf_link_reg;
  logic          rx_take;
  logic          tx_take;
  logic [7:0]    fc;
  logic [15:0]   start_addr;
  logic [15:0]   qty;
  logic          qty_ok;
  logic          addr_ok;
  logic          frame_ok;
  logic          respond;
  logic [5:0]    wr_len;
  logic [6:0]    wait_ms;
  logic [15:0]   reg_val;
  logic [5:0]    dk;
  logic [7:0]    byte_now;

  assign rx_take    = (state_reg == RTU_S_IDLE) && rx_valid;
  assign tx_take    = (state_reg == RTU_S_SEND) && tx_ready;
  assign fc         = rx_buf[`RTU_IX_FC];
  assign start_addr = pair(rx_buf[`RTU_IX_SA], rx_buf[`RTU_IX_SA+1]);
  assign qty        = pair(rx_buf[`RTU_IX_QTY], rx_buf[`RTU_IX_QTY+1]);
  assign qty_ok     = (qty != 16'h0000) && (qty <= `RTU_QTY_MAX);
  assign wr_len     = `RTU_WR_HDR + {qty[4:0], 1'b0};
  assign addr_ok    = (rx_buf[`RTU_IX_ADDR] == `RTU_BCAST) ||
                      ((rx_buf[`RTU_IX_ADDR] == station_address_setting) &&
                       (station_address_setting <= `RTU_ADDR_MAX));
  assign frame_ok   = !rx_ovf_reg && (rx_cnt_reg >= `RTU_MIN_LEN) &&
                      (crc_rx == 16'h0000) && addr_ok;
  assign respond    = (rx_buf[`RTU_IX_ADDR] != `RTU_BCAST) &&
                      (station_address_setting != `RTU_BCAST);
  assign wait_ms    = (transmit_wait_time < `RTU_WAIT_MIN) ? `RTU_WAIT_MIN :
                      (transmit_wait_time > `RTU_WAIT_MAX) ? `RTU_WAIT_MAX :
                      transmit_wait_time;

  rtuslv_gap u_gap (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .byte_seen  (rx_valid),
    .gap_cycles (gap_cycles),
    .frame_end  (frame_end)
  );

  rtuslv_crc u_crc_rx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clr     (state_reg == RTU_S_CHECK),
    .en      (rx_take),
    .data    (rx_data),
    .crc     (crc_rx)
  );

  rtuslv_crc u_crc_tx (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clr     (state_reg == RTU_S_WAIT),
    .en      (tx_take && (k_reg < resp_len_reg - 6'h02)),
    .data    (tx_data),
    .crc     (crc_tx)
  );

  // Receive buffer; bytes arriving while busy are dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_cnt_reg <= 6'h00;
      rx_ovf_reg <= 1'b0;
    end else if (state_reg == RTU_S_CHECK) begin
      rx_cnt_reg <= 6'h00;
      rx_ovf_reg <= 1'b0;
    end else if (rx_take) begin
      if (rx_cnt_reg < `RTU_CNT_MAX) begin
        rx_buf[rx_cnt_reg] <= rx_data;
        rx_cnt_reg         <= rx_cnt_reg + 6'h01;
      end else begin
        rx_ovf_reg <= 1'b1;
      end
    end
  end

  // Main sequence
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= RTU_S_IDLE;
    end else begin
      case (state_reg)
        RTU_S_IDLE: begin
          if (frame_end && (rx_cnt_reg != 6'h00)) begin
            state_reg <= RTU_S_CHECK;
          end
        end
        RTU_S_CHECK: begin
          if (!frame_ok) begin
            state_reg <= RTU_S_IDLE;
          end else if (fc == `RTU_FC_WRITE && qty_ok && rx_cnt_reg == wr_len &&
                       rx_buf[`RTU_IX_BC] == {qty[6:0], 1'b0}) begin
            state_reg <= RTU_S_EXEC;
          end else if (respond) begin
            state_reg <= RTU_S_WAIT;
          end else begin
            state_reg <= RTU_S_IDLE;
          end
        end
        RTU_S_EXEC: begin
          if (wr_idx_reg == qty - 16'h0001) begin
            state_reg <= respond ? RTU_S_WAIT : RTU_S_IDLE;
          end
        end
        RTU_S_WAIT: begin
          if (ms_left_reg == 7'h00) begin
            state_reg <= RTU_S_ADDR;
          end
        end
        RTU_S_ADDR: begin
          state_reg <= RTU_S_LOAD;
        end
        RTU_S_LOAD: begin
          state_reg <= RTU_S_SEND;
        end
        RTU_S_SEND: begin
          if (tx_ready) begin
            state_reg <= (k_reg == resp_len_reg - 6'h01) ? RTU_S_IDLE : RTU_S_ADDR;
          end
        end
        default: begin
          state_reg <= RTU_S_IDLE;
        end
      endcase
    end
  end

  // Reply kind and length, fixed at the check; no source gating
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      kind_reg     <= RTU_K_EXC;
      resp_len_reg <= `RTU_EXC_LEN;
      exc_code_reg <= `RTU_EXC_FUNC;
    end else if (state_reg == RTU_S_CHECK) begin
      kind_reg     <= RTU_K_EXC;
      resp_len_reg <= `RTU_EXC_LEN;
      exc_code_reg <= `RTU_EXC_DATA;
      if (fc == `RTU_FC_READ) begin
        if (qty_ok && rx_cnt_reg == `RTU_CMD_LEN) begin
          kind_reg     <= RTU_K_READ;
          resp_len_reg <= `RTU_RD_OVH + {qty[4:0], 1'b0};
        end
      end else if (fc == `RTU_FC_LOOP) begin
        if (rx_cnt_reg == `RTU_CMD_LEN) begin
          kind_reg     <= RTU_K_LOOP;
          resp_len_reg <= `RTU_CMD_LEN;
        end
      end else if (fc == `RTU_FC_WRITE) begin
        if (qty_ok && rx_cnt_reg == wr_len &&
            rx_buf[`RTU_IX_BC] == {qty[6:0], 1'b0}) begin
          kind_reg     <= RTU_K_WRITE;
          resp_len_reg <= `RTU_CMD_LEN;
        end
      end else begin
        exc_code_reg <= `RTU_EXC_FUNC;
      end
    end
  end

  // Write walk over the received data, one register a cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_idx_reg <= 16'h0000;
      wr_ptr_reg <= `RTU_IX_WDATA;
    end else if (state_reg == RTU_S_EXEC) begin
      wr_idx_reg <= wr_idx_reg + 16'h0001;
      wr_ptr_reg <= wr_ptr_reg + 6'h02;
    end else begin
      wr_idx_reg <= 16'h0000;
      wr_ptr_reg <= `RTU_IX_WDATA;
    end
  end

  // Register port: writes in EXEC, read address ahead of each byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_addr    <= 16'h0000;
      reg_wr_en   <= 1'b0;
      reg_wr_data <= 16'h0000;
    end else begin
      reg_wr_en <= 1'b0;
      if (state_reg == RTU_S_EXEC) begin
        reg_addr    <= start_addr + wr_idx_reg;
        reg_wr_data <= pair(rx_buf[wr_ptr_reg], rx_buf[wr_ptr_reg+6'h01]);
        reg_wr_en   <= 1'b1;
      end else if (state_reg == RTU_S_ADDR) begin
        reg_addr <= start_addr + {11'h000, dk[5:1]};
      end
    end
  end

  // Multi-function commands written over the link
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mf_link_reg <= 10'h000;
    end else if (reg_wr_en && reg_addr == `RTU_MF_REG) begin
      mf_link_reg <= reg_wr_data[15:`RTU_MF_LSB];
    end
  end

  always_ff @(posedge sys_clk) begin
    multi_function_commands <= mf_link_reg | multi_function_input_terminals;
  end

  // Reply delay in whole milliseconds
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ms_cnt_reg  <= 20'h00000;
      ms_left_reg <= `RTU_WAIT_MIN;
    end else if (state_reg != RTU_S_WAIT) begin
      ms_cnt_reg  <= 20'h00000;
      ms_left_reg <= wait_ms;
    end else if (ms_cnt_reg == 20'(MS_CYCLES - 1)) begin
      ms_cnt_reg  <= 20'h00000;
      ms_left_reg <= ms_left_reg - 7'h01;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 20'h00001;
    end
  end

  // Reply byte selection
  assign dk      = k_reg - `RTU_DATA_K;
  assign reg_val = (reg_addr == `RTU_VMON_REG && voltage_monitor_unit_select) ?
                   reg_rd_data / `RTU_VOLT_DIV : reg_rd_data;

  always_comb begin
    byte_now = rx_buf[k_reg];
    if (kind_reg == RTU_K_LOOP) begin
      byte_now = rx_buf[k_reg];
    end else if (k_reg == resp_len_reg - 6'h02) begin
      byte_now = crc_tx[7:0];
    end else if (k_reg == resp_len_reg - 6'h01) begin
      byte_now = crc_tx[15:8];
    end else if (kind_reg == RTU_K_EXC) begin
      if (k_reg == 6'h01) begin
        byte_now = fc | `RTU_EXC_BIT;
      end else if (k_reg == 6'h02) begin
        byte_now = exc_code_reg;
      end
    end else if (kind_reg == RTU_K_READ) begin
      if (k_reg == 6'h02) begin
        byte_now = {qty[6:0], 1'b0};
      end else if (k_reg >= `RTU_DATA_K) begin
        byte_now = dk[0] ? reg_val[7:0] : reg_val[15:8];
      end
    end
  end

  // Transmit side
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      k_reg   <= 6'h00;
      tx_data <= 8'h00;
    end else if (state_reg == RTU_S_WAIT) begin
      k_reg <= 6'h00;
    end else if (state_reg == RTU_S_LOAD) begin
      tx_data <= byte_now;
    end else if (tx_take) begin
      k_reg <= k_reg + 6'h01;
    end
  end

  assign tx_valid = (state_reg == RTU_S_SEND);
  assign rts      = transmit_enable_control_select ?
                    (state_reg == RTU_S_SEND) : 1'b1;

  // Checks
  logic [31:0] wait_cyc;
  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != RTU_S_WAIT) begin
      wait_cyc <= 32'h00000000;
    end else begin
      wait_cyc <= wait_cyc + 32'h00000001;
    end
  end

  sequence s_check_ok;
    state_reg == RTU_S_CHECK && frame_ok;
  endsequence

  sequence s_send_last;
    tx_take && k_reg == resp_len_reg - 6'h01;
  endsequence

  a_reply_caused: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(state_reg == RTU_S_WAIT) |-> $past(state_reg) inside {RTU_S_CHECK, RTU_S_EXEC})
    else $error("reply started without a command");
  a_bcast_silent: assert property (@(posedge sys_clk) disable iff (reset)
    s_check_ok and rx_buf[`RTU_IX_ADDR] == `RTU_BCAST |=> state_reg != RTU_S_WAIT)
    else $error("broadcast answered");
  a_station_zero: assert property (@(posedge sys_clk) disable iff (reset)
    s_check_ok and station_address_setting == `RTU_BCAST |=> state_reg != RTU_S_WAIT)
    else $error("reply with station address zero");
  a_bad_func: assert property (@(posedge sys_clk) disable iff (reset)
    s_check_ok and !(fc inside {`RTU_FC_READ, `RTU_FC_LOOP, `RTU_FC_WRITE})
    |=> kind_reg == RTU_K_EXC && exc_code_reg == `RTU_EXC_FUNC)
    else $error("unsupported function not refused");
  a_read_len: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && kind_reg == RTU_K_READ
    |-> resp_len_reg >= `RTU_RD_MIN && resp_len_reg <= `RTU_RD_MAX)
    else $error("read reply length out of range");
  a_exc_fcode: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == RTU_S_LOAD && kind_reg == RTU_K_EXC && k_reg == 6'h01
    |=> tx_valid && tx_data[7] && resp_len_reg == `RTU_EXC_LEN)
    else $error("error reply function code lacks top bit");
  a_reply_end: assert property (@(posedge sys_clk) disable iff (reset)
    s_send_last |=> state_reg == RTU_S_IDLE && !tx_valid)
    else $error("reply did not end after last byte");
  a_rts_idle: assert property (@(posedge sys_clk) disable iff (reset)
    transmit_enable_control_select && !tx_valid |-> !rts)
    else $error("request-to-send asserted outside transmit");
  a_mf_link: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr_en && reg_addr == `RTU_MF_REG
    |-> ##2 (multi_function_commands & $past(reg_wr_data[15:`RTU_MF_LSB], 2)) ==
        $past(reg_wr_data[15:`RTU_MF_LSB], 2))
    else $error("link command lost");
  a_wait_min: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == RTU_S_WAIT ##1 state_reg == RTU_S_ADDR
    |-> wait_cyc >= 32'(`RTU_WAIT_MIN * MS_CYCLES) - 32'h00000001)
    else $error("reply delay shorter than minimum");
endmodule

// File: hdl/rtuslv_map.svh
// Constants of the serial register protocol slave
`ifndef RTUSLV_MAP_SVH
`define RTUSLV_MAP_SVH
`define RTU_FC_READ     8'h03
`define RTU_FC_LOOP     8'h08
`define RTU_FC_WRITE    8'h10
`define RTU_EXC_BIT     8'h80
`define RTU_EXC_FUNC    8'h01
`define RTU_EXC_DATA    8'h03
`define RTU_BCAST       8'h00
`define RTU_ADDR_MAX    8'h32
`define RTU_CRC_INIT    16'hFFFF
`define RTU_CRC_POLY    16'hA001
`define RTU_BUF_LEN     41
`define RTU_CNT_MAX     6'h29
`define RTU_MIN_LEN     6'h04
`define RTU_QTY_MAX     16'h0010
`define RTU_VMON_REG    16'h0025
`define RTU_MF_REG      16'h0001
`define RTU_MF_LSB      6
`define RTU_VOLT_DIV    16'h000A
`define RTU_WAIT_MIN    7'h05
`define RTU_WAIT_MAX    7'h41
`define RTU_CLK_NS      4
`define RTU_MS_NS       1000000
`define RTU_MS_CYCLES   (`RTU_MS_NS / `RTU_CLK_NS)
`define RTU_CMD_LEN     6'h08
`define RTU_WR_HDR      6'h09
`define RTU_RD_OVH      6'h05
`define RTU_EXC_LEN     6'h05
`define RTU_RD_MIN      6'h07
`define RTU_RD_MAX      6'h25
`define RTU_IX_ADDR     0
`define RTU_IX_FC       1
`define RTU_IX_SA       2
`define RTU_IX_QTY      4
`define RTU_IX_BC       6
`define RTU_IX_WDATA    6'h07
`define RTU_DATA_K      6'h03
`endif

// File: hdl/rtuslv_pkg.sv
// Types of the serial register protocol slave
package rtuslv_pkg;
  typedef enum logic [2:0] {
    RTU_S_IDLE  = 3'b000,
    RTU_S_CHECK = 3'b001,
    RTU_S_EXEC  = 3'b010,
    RTU_S_WAIT  = 3'b011,
    RTU_S_ADDR  = 3'b100,
    RTU_S_LOAD  = 3'b101,
    RTU_S_SEND  = 3'b110
  } rtuslv_state_t;
  typedef enum logic [1:0] {
    RTU_K_EXC   = 2'b00,
    RTU_K_READ  = 2'b01,
    RTU_K_WRITE = 2'b10,
    RTU_K_LOOP  = 2'b11
  } rtuslv_kind_t;
endpackage

// File: hdl/rtuslv_crc.sv
// Byte-wide CRC-16 engine, LSB first
`timescale 1ns/1ns
`include "rtuslv_map.svh"
module rtuslv_crc import rtuslv_pkg::*; (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Control
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // Result
  output logic      [15:0] crc
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RTU_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (reset || clr) begin
      crc <= `RTU_CRC_INIT;
    end else if (en) begin
      crc <= crc_step(crc, data);
    end
  end

  a_crc_preset: assert property (@(posedge sys_clk) disable iff (reset)
    clr |=> crc == `RTU_CRC_INIT)
    else $error("crc not preset to all ones");
endmodule

// File: hdl/rtuslv_gap.sv
// Idle gap timer that marks the end of a frame
`timescale 1ns/1ns
`include "rtuslv_map.svh"
module rtuslv_gap import rtuslv_pkg::*; (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Line activity
  input  wire logic        byte_seen,
  input  wire logic [19:0] gap_cycles,
  // Frame end pulse
  output logic             frame_end
);
  logic [19:0] cnt_reg;
  logic        armed_reg;
  logic [19:0] limit;

  assign limit = (gap_cycles == 20'h00000) ? 20'h00000 : gap_cycles - 20'h00001;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_reg   <= 20'h00000;
      armed_reg <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (byte_seen) begin
        cnt_reg   <= 20'h00000;
        armed_reg <= 1'b1;
      end else if (armed_reg) begin
        if (cnt_reg >= limit) begin
          armed_reg <= 1'b0;
          frame_end <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 20'h00001;
        end
      end
    end
  end

  a_gap_length: assert property (@(posedge sys_clk) disable iff (reset)
    frame_end |-> $past(cnt_reg) >= $past(limit) && !$past(byte_seen))
    else $error("frame ended before the idle gap");
endmodule

// File: tb/rtuslv_master.sv
// Master-side model: sends command frames, collects and checks replies
`timescale 1ns/1ns
module rtuslv_master (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Command bytes to the slave
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  // Reply bytes from the slave
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] reply[$];
  logic       slow;
  int         cyc;
  int         sent_at;
  int         first_at;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    slow     = 1'b0;
    cyc      = 0;
    sent_at  = 0;
    first_at = 0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Residue over a whole reply is zero when its check field is right
  function automatic logic crc_ok();
    return crc16(reply) == 16'h0000;
  endfunction

  task automatic send(input logic [7:0] f[$], input logic corrupt);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, corrupt};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    reply.delete();
    first_at = 0;
    foreach (f[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_data  <= ~f[i];
    end
    sent_at = cyc;
  endtask

  // Stalls two cycles of three when slow
  always @(posedge sys_clk) begin
    cyc      <= cyc + 1;
    tx_ready <= !slow || (cyc % 3 == 0);
    if (tx_valid && tx_ready) begin
      reply.push_back(tx_data);
    end
    if (tx_valid && first_at == 0) begin
      first_at <= cyc;
    end
  end
endmodule

// File: tb/rtu_register_protocol_slave_bench.sv
// Self-checking bench of the serial register protocol slave
`timescale 1ns/1ns
module rtu_register_protocol_slave_bench;
  localparam int MS  = 10;
  localparam int GAP = 16;
  logic        sys_clk;
  logic        reset;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic        rts;
  logic [7:0]  station;
  logic [6:0]  wait_ms;
  logic        ten_sel;
  logic        unit_sel;
  logic [15:0] reg_addr;
  logic [15:0] reg_rd_data;
  logic        reg_wr_en;
  logic [15:0] reg_wr_data;
  logic [9:0]  terms;
  logic [9:0]  mf_cmds;
  logic [31:0] wr_log[$];
  int          errors;
  int          total_checks;
  int          rts_bad;

  rtuslv_top #(.MS_CYCLES(MS)) rtuslv_top_inst (
    .sys_clk(sys_clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
    .gap_cycles(20'(GAP)), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rts(rts), .station_address_setting(station), .transmit_wait_time(wait_ms),
    .transmit_enable_control_select(ten_sel), .voltage_monitor_unit_select(unit_sel),
    .reg_addr(reg_addr), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .multi_function_input_terminals(terms),
    .multi_function_commands(mf_cmds));

  rtuslv_master rtuslv_master_inst (
    .sys_clk(sys_clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  function automatic logic [15:0] rd_val(input logic [15:0] a);
    return {a[7:0] ^ 8'h3C, a[7:0] + 8'h11};
  endfunction

  assign reg_rd_data = rd_val(reg_addr);

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (reg_wr_en === 1'b1) begin
      wr_log.push_back({reg_addr, reg_wr_data});
    end
  end

  always @(negedge sys_clk) begin
    if (!reset && rts !== (ten_sel ? tx_valid : 1'b1)) begin
      rts_bad++;
    end
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_reply(input logic [7:0] e[$]);
    cmp_val(32'(rtuslv_master_inst.reply.size()), 32'(e.size()));
    foreach (e[i]) begin
      if (i < rtuslv_master_inst.reply.size()) begin
        cmp_val(32'(rtuslv_master_inst.reply[i]), 32'(e[i]));
      end
    end
  endtask

  task automatic seal(ref logic [7:0] e[$]);
    logic [15:0] c;
    c = rtuslv_master_inst.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
  endtask

  // Sends one frame, waits for the whole reply or for silence, judges it
  task automatic run(input logic [7:0] f[$], input logic corrupt, input logic [7:0] e[$]);
    int n;
    int lo;
    rts_bad = 0;
    rtuslv_master_inst.send(f, corrupt);
    n = 0;
    while (n < 600 && (e.size() == 0 || rtuslv_master_inst.reply.size() < e.size())) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (40) @(posedge sys_clk);
    cmp_reply(e);
    cmp_val(32'(rts_bad), 32'h0);
    if (e.size() > 0) begin
      lo = (wait_ms < 5 ? 5 : (wait_ms > 65 ? 65 : int'(wait_ms))) * MS;
      n = rtuslv_master_inst.first_at - rtuslv_master_inst.sent_at;
      cmp_val(32'(n >= lo && n <= lo + GAP + 12), 32'h1);
      cmp_val(32'(rtuslv_master_inst.crc_ok()), 32'h1);
    end
  endtask

  task automatic t_read();
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [15:0] v;
    station <= 8'h02;
    ten_sel <= 1'b1;
    rtuslv_master_inst.slow = 1'b1;
    f = '{8'h02, 8'h03, 8'h00, 8'h20, 8'h00, 8'h04};
    cmp_val(32'(rtuslv_master_inst.crc16(f)), 32'h0000F045);
    e = '{8'h02, 8'h03, 8'h08};
    for (int a = 32; a < 36; a++) begin
      v = rd_val(16'(a));
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    seal(e);
    run(f, 1'b0, e);
    rtuslv_master_inst.slow = 1'b0;
    $display("test read done");
  endtask

  task automatic t_loop();
    logic [7:0] f[$];
    logic [7:0] e[$];
    station <= 8'h01;
    ten_sel <= 1'b0;
    f = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37};
    e = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8D};
    run(f, 1'b0, e);
    station <= 8'h32;
    f = '{8'h32, 8'h08, 8'h12, 8'h34, 8'h56, 8'h78};
    e = f;
    seal(e);
    run(f, 1'b0, e);
    $display("test loopback done");
  endtask

  task automatic t_write();
    logic [7:0] f[$];
    logic [7:0] e[$];
    station <= 8'h01;
    wr_log.delete();
    f = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h58};
    e = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h10, 8'h08};
    run(f, 1'b0, e);
    cmp_val(32'(wr_log.size()), 32'h2);
    cmp_val(wr_log[0], 32'h00010001);
    cmp_val(wr_log[1], 32'h00020258);
    wr_log.delete();
    f = '{8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h55, 8'h40};
    e.delete();
    run(f, 1'b0, e);
    cmp_val(wr_log[0], 32'h00015540);
    cmp_val(32'(mf_cmds), 32'h15F);
    terms <= 10'h200;
    repeat (2) @(posedge sys_clk);
    cmp_val(32'(mf_cmds), 32'h355);
    $display("test write done");
  endtask

  task automatic t_exc();
    logic [7:0] f[$];
    logic [7:0] e[$];
    station <= 8'h02;
    f = '{8'h02, 8'h03, 8'h00, 8'h20, 8'h00, 8'h00};
    e = '{8'h02, 8'h83, 8'h03, 8'hF1, 8'h31};
    run(f, 1'b0, e);
    station <= 8'h01;
    f = '{8'h01, 8'h09, 8'h00, 8'h00, 8'hA5, 8'h37};
    e = '{8'h01, 8'h89, 8'h01, 8'h86, 8'h50};
    run(f, 1'b0, e);
    $display("test exception done");
  endtask

  task automatic t_drop();
    logic [7:0] f[$];
    logic [7:0] e[$];
    station <= 8'h01;
    f = '{8'h03, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37};
    run(f, 1'b0, e);
    f[0] = 8'h01;
    run(f, 1'b1, e);
    station <= 8'h33;
    f[0] = 8'h33;
    run(f, 1'b0, e);
    station <= 8'h00;
    f[0] = 8'h00;
    run(f, 1'b0, e);
    $display("test drop done");
  endtask

  task automatic t_unit();
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [15:0] v;
    station  <= 8'h01;
    wait_ms  <= 7'h02;
    f = '{8'h01, 8'h03, 8'h00, 8'h25, 8'h00, 8'h01};
    v = rd_val(16'h0025);
    for (int u = 0; u < 2; u++) begin
      e = '{8'h01, 8'h03, 8'h02, v[15:8], v[7:0]};
      seal(e);
      run(f, 1'b0, e);
      unit_sel <= 1'b1;
      wait_ms  <= 7'h0C;
      v = v / 16'h000A;
    end
    $display("test unit done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk      = 1'b0;
    reset        = 1'b1;
    station      = 8'h01;
    wait_ms      = 7'h05;
    ten_sel      = 1'b0;
    unit_sel     = 1'b0;
    terms        = 10'h00A;
    errors       = 0;
    total_checks = 0;
    rts_bad      = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_read();
    t_loop();
    t_write();
    t_exc();
    t_drop();
    t_unit();
    test_done();
  end

  // Whole run needs about five thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    test_done();
  end
endmodule
